//--- verilog/gpb_defs.vh
// Register offsets, reset values and widths for the port D..G register bank.
// Assumes includers use these as plain text macros.
`ifndef GPB_DEFS_VH
`define GPB_DEFS_VH
// ----------------------------------------
// Address spaces
// ----------------------------------------
`define GPB_IO_TOP 8'h3f
`define GPB_DS_IO_BIAS 8'h20
`define GPB_EXT_BASE 8'h60
// ----------------------------------------
// I/O offsets (low range) and data addresses (extended range)
// ----------------------------------------
`define GPB_OFS_F_LVL 8'h00
`define GPB_OFS_E_LVL 8'h01
`define GPB_OFS_E_DIR 8'h02
`define GPB_OFS_E_OUT 8'h03
`define GPB_OFS_D_LVL 8'h10
`define GPB_OFS_D_DIR 8'h11
`define GPB_OFS_D_OUT 8'h12
`define GPB_ADR_F_DIR 8'h61
`define GPB_ADR_F_OUT 8'h62
`define GPB_ADR_G_LVL 8'h63
`define GPB_ADR_G_DIR 8'h64
`define GPB_ADR_G_OUT 8'h65
// ----------------------------------------
// Reset values and port G mask
// ----------------------------------------
`define GPB_RST_VAL 8'h00
`define GPB_G_MASK 8'h1f
`endif

//--- verilog/gpb_port_bank.v
// Output data, direction and pin level registers for ports D, E, F and G.
// Assumes one CPU access per cycle: either an I/O-space access (short I/O
// instructions, offset only) or a data-space access (load/store, full address).
// Read data is registered and valid the cycle after the read strobe.
`timescale 1ns/1ps
`include "gpb_defs.vh"
module gpb_port_bank #(
   parameter G_WIDTH = 5
) (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // CPU register access
   input wire i_io_space,
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   output reg o_hit,
   // Mode
   input wire i_legacy_mode,
   // Pins
   input wire [7:0] i_pin_d,
   input wire [7:0] i_pin_e,
   input wire [7:0] i_pin_f,
   input wire [G_WIDTH-1:0] i_pin_g,
   output reg [7:0] o_pin_d,
   output reg [7:0] o_pin_e,
   output reg [7:0] o_pin_f,
   output reg [G_WIDTH-1:0] o_pin_g,
   output reg [7:0] o_pin_d_oe,
   output reg [7:0] o_pin_e_oe,
   output reg [7:0] o_pin_f_oe,
   output reg [G_WIDTH-1:0] o_pin_g_oe
);
   // ----------------------------------------
   // Address translation
   // ----------------------------------------
   // Output data and direction state per port
   reg [7:0] d_out_r;
   reg [7:0] d_dir_r;
   reg [7:0] e_out_r;
   reg [7:0] e_dir_r;
   reg [7:0] f_out_r;
   reg [7:0] f_dir_r;
   reg [G_WIDTH-1:0] g_out_r;
   reg [G_WIDTH-1:0] g_dir_r;
   // Pin level samples; no reset, they simply follow the pins
   reg [7:0] lvl_d_r;
   reg [7:0] lvl_e_r;
   reg [7:0] lvl_f_r;
   reg [G_WIDTH-1:0] lvl_g_r;
   reg [7:0] rdata_nxt;
   reg hit_nxt;
   reg low_ok;
   reg ext_ok;
   reg [7:0] low_ofs;
   wire [7:0] g_wmask;
   wire acc;
   assign acc = i_wr | i_rd;
   assign g_wmask = `GPB_G_MASK;

   // Port G is narrower than the bus; the missing upper bits read as zero
   wire [7:0] g_lvl_rd;
   wire [7:0] g_dir_rd;
   wire [7:0] g_out_rd;
   assign g_lvl_rd = {{(8-G_WIDTH){1'b0}}, lvl_g_r};
   assign g_dir_rd = {{(8-G_WIDTH){1'b0}}, g_dir_r};
   assign g_out_rd = {{(8-G_WIDTH){1'b0}}, g_out_r};

   // Map either access kind onto a low-range offset; extended range only from data space
   always @* begin
      low_ok = 1'b0;
      ext_ok = 1'b0;
      low_ofs = 8'h00;
      if (i_io_space) begin
         low_ok = (i_addr <= `GPB_IO_TOP);
         low_ofs = i_addr;
      end else if (i_addr >= `GPB_EXT_BASE) begin
         ext_ok = 1'b1;
      end else if (i_addr >= `GPB_DS_IO_BIAS) begin
         low_ok = 1'b1;
         low_ofs = i_addr - `GPB_DS_IO_BIAS;
      end
   end

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   // Legacy mode hides F/G output and direction, so those addresses miss
   always @* begin
      rdata_nxt = 8'h00;
      hit_nxt = 1'b0;
      if (low_ok && low_ofs == `GPB_OFS_F_LVL) begin
         rdata_nxt = lvl_f_r;
         hit_nxt = 1'b1;
      end else if (low_ok && low_ofs == `GPB_OFS_E_LVL) begin
         rdata_nxt = lvl_e_r;
         hit_nxt = 1'b1;
      end else if (low_ok && low_ofs == `GPB_OFS_E_DIR) begin
         rdata_nxt = e_dir_r;
         hit_nxt = 1'b1;
      end else if (low_ok && low_ofs == `GPB_OFS_E_OUT) begin
         rdata_nxt = e_out_r;
         hit_nxt = 1'b1;
      end else if (low_ok && low_ofs == `GPB_OFS_D_LVL) begin
         rdata_nxt = lvl_d_r;
         hit_nxt = 1'b1;
      end else if (low_ok && low_ofs == `GPB_OFS_D_DIR) begin
         rdata_nxt = d_dir_r;
         hit_nxt = 1'b1;
      end else if (low_ok && low_ofs == `GPB_OFS_D_OUT) begin
         rdata_nxt = d_out_r;
         hit_nxt = 1'b1;
      end else if (ext_ok && i_addr == `GPB_ADR_F_DIR && !i_legacy_mode) begin
         rdata_nxt = f_dir_r;
         hit_nxt = 1'b1;
      end else if (ext_ok && i_addr == `GPB_ADR_F_OUT && !i_legacy_mode) begin
         rdata_nxt = f_out_r;
         hit_nxt = 1'b1;
      end else if (ext_ok && i_addr == `GPB_ADR_G_LVL) begin
         rdata_nxt = g_lvl_rd;
         hit_nxt = 1'b1;
      end else if (ext_ok && i_addr == `GPB_ADR_G_DIR && !i_legacy_mode) begin
         rdata_nxt = g_dir_rd;
         hit_nxt = 1'b1;
      end else if (ext_ok && i_addr == `GPB_ADR_G_OUT && !i_legacy_mode) begin
         rdata_nxt = g_out_rd;
         hit_nxt = 1'b1;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Writes to level registers fall through: read-only
   always @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         d_out_r <= `GPB_RST_VAL;
         d_dir_r <= `GPB_RST_VAL;
         e_out_r <= `GPB_RST_VAL;
         e_dir_r <= `GPB_RST_VAL;
         f_out_r <= `GPB_RST_VAL;
         f_dir_r <= `GPB_RST_VAL;
         g_out_r <= {G_WIDTH{1'b0}};
         g_dir_r <= {G_WIDTH{1'b0}};
      end else if (i_wr) begin
         if (low_ok && low_ofs == `GPB_OFS_D_DIR) begin
            d_dir_r <= i_wdata;
         end else if (low_ok && low_ofs == `GPB_OFS_D_OUT) begin
            d_out_r <= i_wdata;
         end else if (low_ok && low_ofs == `GPB_OFS_E_DIR) begin
            e_dir_r <= i_wdata;
         end else if (low_ok && low_ofs == `GPB_OFS_E_OUT) begin
            e_out_r <= i_wdata;
         end else if (ext_ok && i_addr == `GPB_ADR_F_DIR && !i_legacy_mode) begin
            f_dir_r <= i_wdata;
         end else if (ext_ok && i_addr == `GPB_ADR_F_OUT && !i_legacy_mode) begin
            f_out_r <= i_wdata;
         end else if (ext_ok && i_addr == `GPB_ADR_G_DIR && !i_legacy_mode) begin
            g_dir_r <= i_wdata[G_WIDTH-1:0] & g_wmask[G_WIDTH-1:0];
         end else if (ext_ok && i_addr == `GPB_ADR_G_OUT && !i_legacy_mode) begin
            g_out_r <= i_wdata[G_WIDTH-1:0] & g_wmask[G_WIDTH-1:0];
         end
      end
   end

   // Read data registered; reads have no side effects
   always @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
         o_hit <= 1'b0;
      end else begin
         o_rdata <= i_rd ? rdata_nxt : 8'h00;
         o_hit <= acc & hit_nxt;
      end
   end

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   // Level registers sample pins every cycle, one cycle of latency; value tracks pins
   always @(posedge i_clk_sys) begin
      lvl_d_r <= i_pin_d;
      lvl_e_r <= i_pin_e;
      lvl_f_r <= i_pin_f;
      lvl_g_r <= i_pin_g;
   end

   // Drive only where direction is one; legacy mode forces F and G to inputs
   always @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_pin_d <= 8'h00;
         o_pin_e <= 8'h00;
         o_pin_f <= 8'h00;
         o_pin_g <= {G_WIDTH{1'b0}};
         o_pin_d_oe <= 8'h00;
         o_pin_e_oe <= 8'h00;
         o_pin_f_oe <= 8'h00;
         o_pin_g_oe <= {G_WIDTH{1'b0}};
      end else begin
         o_pin_d <= d_out_r & d_dir_r;
         o_pin_e <= e_out_r & e_dir_r;
         o_pin_f <= i_legacy_mode ? 8'h00 : (f_out_r & f_dir_r);
         o_pin_g <= i_legacy_mode ? {G_WIDTH{1'b0}} : (g_out_r & g_dir_r);
         o_pin_d_oe <= d_dir_r;
         o_pin_e_oe <= e_dir_r;
         o_pin_f_oe <= i_legacy_mode ? 8'h00 : f_dir_r;
         o_pin_g_oe <= i_legacy_mode ? {G_WIDTH{1'b0}} : g_dir_r;
      end
   end
endmodule

//--- dv/gpb_chk_assertions.sv
// Assertions on the port bank read path and pin drivers.
// Assumes pin inputs stay steady around level reads.
`timescale 1ns/1ps
module gpb_chk #(parameter G_WIDTH = 5) (
   // Clock, reset and access
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_io_space,
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   input wire o_hit,
   // Mode and pins
   input wire i_legacy_mode,
   input wire [7:0] i_pin_e,
   input wire [7:0] o_pin_e_oe,
   input wire [7:0] o_pin_d_oe,
   input wire [7:0] o_pin_f_oe,
   input wire [G_WIDTH-1:0] o_pin_g_oe
);
   // ------
   // Properties
   // ------
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   chk_io_range: assert property (i_rd && i_io_space && i_addr > 8'h3f |=> !o_hit && o_rdata == 8'h00)
      else $error("io access above range answered");
   chk_ds_bias: assert property (i_rd && !i_io_space && i_addr == 8'h21 |=> o_hit && o_rdata == $past(i_pin_e, 2))
      else $error("biased level read wrong");
   chk_ext_reach: assert property (i_rd && !i_io_space && i_addr > 8'h60 && i_addr < 8'h66 && !i_legacy_mode |=> o_hit)
      else $error("extended read missed");
   // Reset must not disable its own check
   chk_reset_clear: assert property (disable iff (1'b0) !i_rst_b ##1 !i_rst_b |-> !o_hit && (o_pin_d_oe | o_pin_e_oe) == 8'h00)
      else $error("outputs not cleared in reset");
   chk_level_write: assert property (i_wr && i_io_space && i_addr == 8'h10 |=> o_hit)
      else $error("level write not acknowledged");
   chk_g_upper: assert property (i_rd && !i_io_space && i_addr == 8'h64 |=> o_rdata[7:5] == 3'h0)
      else $error("upper port g bits not zero");
   chk_legacy_f: assert property (i_legacy_mode |=> o_pin_f_oe == 8'h00)
      else $error("port f drives in legacy mode");
   chk_legacy_g: assert property (i_legacy_mode |=> o_pin_g_oe == '0)
      else $error("port g drives in legacy mode");
   chk_dir_to_oe: assert property (i_wr && i_io_space && i_addr == 8'h02 |-> ##2 o_pin_e_oe == $past(i_wdata, 2))
      else $error("direction write not on enables");
endmodule
bind gpb_port_bank gpb_chk #(.G_WIDTH(G_WIDTH)) chk_u (
   .i_clk_sys(i_clk_sys),
   .i_rst_b(i_rst_b),
   .i_io_space(i_io_space),
   .i_addr(i_addr),
   .i_wr(i_wr),
   .i_rd(i_rd),
   .i_wdata(i_wdata),
   .o_rdata(o_rdata),
   .o_hit(o_hit),
   .i_legacy_mode(i_legacy_mode),
   .i_pin_e(i_pin_e),
   .o_pin_e_oe(o_pin_e_oe),
   .o_pin_d_oe(o_pin_d_oe),
   .o_pin_f_oe(o_pin_f_oe),
   .o_pin_g_oe(o_pin_g_oe)
);

//--- dv/gpio_port_bank_d_to_g_test.sv
// Self-checking bench for the port D..G register bank.
// Assumes read data answers one cycle after the strobe.
`timescale 1ns/1ps
module gpio_port_bank_d_to_g_test;
   logic clk = 0, rst_b = 0, io = 0, wr = 0, rd = 0, leg = 0;
   logic [7:0] addr = 0, wd = 0, pd = 8'h81, pe = 8'h3c, pf = 8'h0f;
   logic [4:0] pg = 5'h15;
   wire [7:0] rdata, od, oe, of, odo, oeo, ofo;
   wire [4:0] og, ogo;
   wire hit;
   int num_errors = 0, num_checks = 0;
   // Rows: io space, address, write data, read back, hit
   logic [25:0] rows [15] = '{{1'b1, 8'h02, 8'ha5, 8'ha5, 1'b1}, {1'b0, 8'h23, 8'h3c, 8'h3c, 1'b1},
      {1'b1, 8'h11, 8'h5a, 8'h5a, 1'b1}, {1'b1, 8'h12, 8'hc3, 8'hc3, 1'b1}, {1'b0, 8'h61, 8'h96, 8'h96, 1'b1},
      {1'b0, 8'h62, 8'h69, 8'h69, 1'b1}, {1'b0, 8'h64, 8'hff, 8'h1f, 1'b1}, {1'b0, 8'h65, 8'he7, 8'h07, 1'b1},
      {1'b1, 8'h10, 8'hff, 8'h81, 1'b1}, {1'b0, 8'h21, 8'h00, 8'h3c, 1'b1}, {1'b1, 8'h00, 8'hff, 8'h0f, 1'b1},
      {1'b0, 8'h63, 8'hff, 8'h15, 1'b1}, {1'b1, 8'h41, 8'hff, 8'h00, 1'b0}, {1'b1, 8'h61, 8'hff, 8'h00, 1'b0},
      {1'b0, 8'h10, 8'hff, 8'h00, 1'b0}};
   // Writable places that must come back cleared
   logic [8:0] zr [8] = '{9'h111, 9'h112, 9'h102, 9'h103, 9'h061, 9'h062, 9'h064, 9'h065};
   always #50 clk = ~clk;
   gpb_port_bank dut_u (.i_clk_sys(clk), .i_rst_b(rst_b), .i_io_space(io), .i_addr(addr), .i_wr(wr), .i_rd(rd),
      .i_wdata(wd), .o_rdata(rdata), .o_hit(hit), .i_legacy_mode(leg), .i_pin_d(pd), .i_pin_e(pe), .i_pin_f(pf),
      .i_pin_g(pg), .o_pin_d(od), .o_pin_e(oe), .o_pin_f(of), .o_pin_g(og), .o_pin_d_oe(odo), .o_pin_e_oe(oeo),
      .o_pin_f_oe(ofo), .o_pin_g_oe(ogo));
   // ------
   // Tasks
   // ------
   task cmp(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One strobe cycle; read data and hit are settled when it returns, pin outputs a cycle later
   task acc(input logic w, r, s, input logic [7:0] a, d);
      @(posedge clk) #1;
      {wr, rd, io, addr, wd} = {w, r, s, a, d};
      @(posedge clk) #1;
      {wr, rd} = 2'b00;
   endtask
   task rd_chk(input logic s, input logic [7:0] a, exp, input logic h);
      acc(0, 1, s, a, 8'h00);
      cmp(rdata, exp);
      cmp({7'h0, hit}, {7'h0, h});
   endtask
   task reset_dut;
      rst_b = 0;
      repeat (16) @(posedge clk);
      #1 rst_b = 1;
   endtask
   task end_sim;
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ------
   // Tests
   // ------
   initial begin
      reset_dut;
      foreach (rows[i]) begin
         acc(1, 0, rows[i][25], rows[i][24:17], rows[i][16:9]);
         rd_chk(rows[i][25], rows[i][24:17], rows[i][8:1], rows[i][0]);
      end
      cmp(odo, 8'h5a);
      cmp(od, 8'h42);
      cmp(oe, 8'h24);
      cmp(ofo, 8'h96);
      cmp({3'h0, og}, 8'h07);
      cmp(oeo, 8'ha5);
      cmp({3'h0, ogo}, 8'h1f);
      cmp(of, 8'h00);
      // Legacy hides F and G outputs; a write there must be dropped
      leg = 1;
      acc(1, 0, 0, 8'h62, 8'h11);
      cmp(ofo | {3'h0, ogo}, 8'h00);
      rd_chk(0, 8'h61, 8'h00, 0);
      rd_chk(0, 8'h65, 8'h00, 0);
      rd_chk(0, 8'h63, 8'h15, 1);
      leg = 0;
      rd_chk(0, 8'h62, 8'h69, 1);
      // Port F drives only where its direction is set; the pin follows the register a cycle later
      acc(1, 0, 0, 8'h62, 8'hff);
      @(posedge clk) #1;
      cmp(of, 8'h96);
      // Second reset in mid-run clears everything writable
      reset_dut;
      cmp(odo | oeo | ofo | {3'h0, ogo}, 8'h00);
      cmp(od | oe | of | {3'h0, og}, 8'h00);
      foreach (zr[i]) rd_chk(zr[i][8], zr[i][7:0], 8'h00, 1);
      end_sim;
   end
   // Watchdog far beyond the roughly 120 cycles the tests need
   initial begin
      #100000;
      num_errors++;
      end_sim;
   end
endmodule
